// file: logic/reset_cause_consts.svh
// named offsets, field positions, reset values and codes for the reset cause block
`ifndef RESET_CAUSE_CONSTS_SVH
`define RESET_CAUSE_CONSTS_SVH

// register indices; the byte address on the bus is four times the index
`define IDX_CORE_STATUS 10'h003
`define IDX_IRQ_CONTROL 10'h00B
`define IDX_PERIPH_FLAGS 10'h00C
`define IDX_COMPARATOR 10'h01F
`define IDX_OPTION 10'h081
`define IDX_PORTB_DIR 10'h086
`define IDX_POWER_CAUSE 10'h08E
`define IDX_EVT_STATUS 10'h0A0
`define IDX_EVT_CLEAR 10'h0A1
`define IDX_EVT_ENABLE 10'h0A2

// core status fields
`define ST_TIMEOUT 4
`define ST_POWERDOWN 3
`define ST_TOP_MASK 8'hE0
`define ST_WRITE_MASK 8'hE7
`define ST_LOW_MASK 8'h07

// power cause fields
`define PCAUSE_POR 1
`define PCAUSE_BOR 0

// interrupt control and peripheral flag fields
`define IRQ_GIE 7
`define IRQ_EXT_FLAG 1
`define IRQ_RB_FLAG 0
`define IRQ_RESET_MASK 8'h01
`define PIR_CMP_FLAG 6

// values loaded by resets and wake-ups
`define PC_RESET 13'h0000
`define PC_VECTOR 13'h0004
`define PC_STEP 13'h0001
`define OPTION_RST 8'hFF
`define PORTB_DIR_RST 8'hFF
`define CMP_RST 6'h00

// event bits of the interrupt status register
`define EV_POR 0
`define EV_BOR 1
`define EV_MASTER_CLEAR_PIN_RUN 2
`define EV_MASTER_CLEAR_PIN_SLEEP 3
`define EV_WDT_RESET 4
`define EV_WDT_WAKE 5
`define EV_IRQ_WAKE 6

`endif

// file: logic/reset_cause_pkg.sv
// types shared by the reset cause block
package reset_cause_pkg;

	// reset requests from the supervisory circuits
	typedef struct packed {
		logic por;
		logic bor;
		logic master_clear_pin;
		logic wdt;
	} reset_req_t;

	// wake requests, valid only while the core sleeps
	typedef struct packed {
		logic wdt;
		logic ext_int;
		logic rb_change;
		logic cmp;
	} wake_req_t;

	// program counter sequencer
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_WAIT = 2'b01
	} seq_state_t;

	// the whole state of the block
	typedef struct packed {
		logic [7:0] core_status;
		logic [1:0] power_cause;
		logic [7:0] irq_control;
		logic periph_cmp;
		logic [5:0] comparator;
		logic [7:0] option;
		logic [7:0] portb_direction;
		logic [6:0] evt_status;
		logic [6:0] evt_enable;
		seq_state_t seq;
		logic pc_load;
		logic [12:0] pc_value;
		logic ahb_wr;
		logic [9:0] ahb_idx;
		logic [31:0] hrdata;
	} state_t;

endpackage

// file: logic/reset_cause_and_init_state.sv
// reset cause recording, initial values and program counter load for the core
`timescale 1ns/1ps
`include "reset_cause_consts.svh"

// Behaviour
// - power-on reset sets the time-out flag to one
// - power-on reset sets the power-down flag to one
// - interrupt wake with global enable: run PC+1, then load vector 0004h
// - interrupt or watchdog wake-up resumes at PC+1, not the reset address
// - brown-out reset clears brown-out cause bit; other resets keep it
// - comparator wake-up sets peripheral flag bit 6; other wakes leave it
// - interrupt wake-up sets the flag bits of the waking source
// - power-on during another reset applies the power-on values
// - unimplemented bits of the initialised registers read as zero
// - master clear while running: PC 000h, top status bits cleared, rest kept
// - master clear asleep: PC 000h, time-out 1, power-down 0, top bits cleared
// - watchdog reset clears top bits and both flags; brown-out clears top bits
// - watchdog wake clears both flags; interrupt wake sets time-out, clears power-down
// - every reset sets option and port B direction to ones, clears comparator
// - power-on cause bit reads 0 after power-on, else kept; software sets it
module reset_cause_and_init_state
	import reset_cause_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire reset_req_t reset_req_i,
	input wire wake_req_t wake_req_i,
	input wire logic sleeping_i,
	input wire logic [12:0] pc_i,
	input wire logic core_step_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic pc_load_o,
	output logic [12:0] pc_value_o,
	output logic [7:0] option_o,
	output logic [7:0] portb_direction_o,
	output logic [5:0] comparator_o,
	output logic irq_o
);

	state_t st;
	state_t next_st;

	logic any_reset;
	logic do_por;
	logic do_bor;
	logic do_master_clear_pin;
	logic do_wdt;
	logic wake_go;
	logic irq_wake;
	logic addr_take;
	logic [6:0] events;

	// true for every index the register file answers
	function automatic logic reg_hit(input logic [9:0] idx);
		unique case (idx)
			`IDX_CORE_STATUS, `IDX_IRQ_CONTROL, `IDX_PERIPH_FLAGS, `IDX_COMPARATOR,
			`IDX_OPTION, `IDX_PORTB_DIR, `IDX_POWER_CAUSE, `IDX_EVT_STATUS,
			`IDX_EVT_CLEAR, `IDX_EVT_ENABLE: reg_hit = 1'b1;
			default: reg_hit = 1'b0;
		endcase
	endfunction

	// read view of a register; narrow and unimplemented bits read as zero
	function automatic logic [31:0] read_reg(input logic [9:0] idx, input state_t s);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (reg_hit(idx)) begin
			unique case (idx)
				`IDX_CORE_STATUS: v[7:0] = s.core_status;
				`IDX_IRQ_CONTROL: v[7:0] = s.irq_control;
				`IDX_PERIPH_FLAGS: v[`PIR_CMP_FLAG] = s.periph_cmp;
				`IDX_COMPARATOR: v[5:0] = s.comparator;
				`IDX_OPTION: v[7:0] = s.option;
				`IDX_PORTB_DIR: v[7:0] = s.portb_direction;
				`IDX_POWER_CAUSE: v[1:0] = s.power_cause;
				`IDX_EVT_STATUS: v[6:0] = s.evt_status;
				`IDX_EVT_ENABLE: v[6:0] = s.evt_enable;
				default: v = 32'h0000_0000; // clear register is write-only
			endcase
		end
		read_reg = v;
	endfunction

	// one winner among reset requests; power-on beats everything
	always_comb begin
		do_por = reset_req_i.por;
		do_bor = reset_req_i.bor && !reset_req_i.por;
		do_master_clear_pin = reset_req_i.master_clear_pin && !reset_req_i.por && !reset_req_i.bor;
		do_wdt = reset_req_i.wdt && !reset_req_i.por && !reset_req_i.bor
			&& !reset_req_i.master_clear_pin;
		any_reset = do_por || do_bor || do_master_clear_pin || do_wdt;
		// wakes only count while asleep and when no reset is pending
		wake_go = sleeping_i && !any_reset && (wake_req_i != 4'h0);
		irq_wake = wake_go && (wake_req_i.ext_int || wake_req_i.rb_change || wake_req_i.cmp);
		addr_take = hsel_i && htrans_i[1] && hready_i;
	end

	// events for the interrupt status register
	always_comb begin
		events = 7'h00;
		events[`EV_POR] = do_por;
		events[`EV_BOR] = do_bor;
		events[`EV_MASTER_CLEAR_PIN_RUN] = do_master_clear_pin && !sleeping_i;
		events[`EV_MASTER_CLEAR_PIN_SLEEP] = do_master_clear_pin && sleeping_i;
		events[`EV_WDT_RESET] = do_wdt;
		events[`EV_WDT_WAKE] = wake_go && wake_req_i.wdt;
		events[`EV_IRQ_WAKE] = irq_wake;
	end

	// next state: bus writes first, then hardware causes override them
	always_comb begin
		next_st = st;
		next_st.pc_load = 1'b0;
		next_st.ahb_wr = 1'b0;

		// data phase of a write; only whole words are issued by the master
		if (st.ahb_wr) begin
			unique case (st.ahb_idx)
				`IDX_CORE_STATUS: next_st.core_status = (st.core_status & ~`ST_WRITE_MASK)
					| (hwdata_i[7:0] & `ST_WRITE_MASK);
				`IDX_IRQ_CONTROL: next_st.irq_control = hwdata_i[7:0];
				`IDX_PERIPH_FLAGS: next_st.periph_cmp = hwdata_i[`PIR_CMP_FLAG];
				`IDX_COMPARATOR: next_st.comparator = hwdata_i[5:0];
				`IDX_OPTION: next_st.option = hwdata_i[7:0];
				`IDX_PORTB_DIR: next_st.portb_direction = hwdata_i[7:0];
				`IDX_POWER_CAUSE: next_st.power_cause = hwdata_i[1:0];
				`IDX_EVT_CLEAR: next_st.evt_status = st.evt_status & ~hwdata_i[6:0];
				`IDX_EVT_ENABLE: next_st.evt_enable = hwdata_i[6:0];
				default: next_st.evt_enable = st.evt_enable; // event status is read-only: ignored
			endcase
		end

		// sticky events; a set in the clearing cycle wins
		next_st.evt_status = next_st.evt_status | events;

		// address phase capture; read data registered for the data phase
		if (addr_take) begin
			next_st.ahb_wr = hwrite_i && reg_hit(haddr_i[11:2]);
			next_st.ahb_idx = haddr_i[11:2];
			next_st.hrdata = read_reg(haddr_i[11:2], st);
		end

		// the program counter sequencer finishes a pending vector branch
		if (st.seq == SEQ_WAIT && core_step_i && !any_reset) begin
			next_st.pc_load = 1'b1;
			next_st.pc_value = `PC_VECTOR;
			next_st.seq = SEQ_IDLE;
		end

		// every reset: common register defaults and PC at the reset address
		if (any_reset) begin
			next_st.pc_load = 1'b1;
			next_st.pc_value = `PC_RESET;
			next_st.seq = SEQ_IDLE;
			next_st.option = `OPTION_RST;
			next_st.portb_direction = `PORTB_DIR_RST;
			next_st.comparator = `CMP_RST;
			next_st.periph_cmp = 1'b0;
			next_st.core_status = st.core_status & ~`ST_TOP_MASK;
			next_st.irq_control = st.irq_control & `IRQ_RESET_MASK;
		end

		// per cause status and power cause values
		if (do_por) begin
			// power-on wins over any other pending cause
			next_st.core_status[`ST_TIMEOUT] = 1'b1;
			next_st.core_status[`ST_POWERDOWN] = 1'b1;
			next_st.power_cause[`PCAUSE_POR] = 1'b0;
			// global enable is undefined at power-up, so it is kept; the rest clears
			next_st.irq_control[`IRQ_GIE] = st.irq_control[`IRQ_GIE];
			next_st.irq_control[`IRQ_RB_FLAG] = 1'b0;
		end else if (do_bor) begin
			// both flags are undefined here; they keep their old values
			next_st.power_cause[`PCAUSE_BOR] = 1'b0;
		end else if (do_master_clear_pin && sleeping_i) begin
			next_st.core_status[`ST_TIMEOUT] = 1'b1;
			next_st.core_status[`ST_POWERDOWN] = 1'b0;
		end else if (do_wdt) begin
			next_st.core_status[`ST_TIMEOUT] = 1'b0;
			next_st.core_status[`ST_POWERDOWN] = 1'b0;
		end

		// wake-ups continue in line instead of restarting
		if (wake_go) begin
			next_st.pc_load = 1'b1;
			next_st.pc_value = 13'(pc_i + `PC_STEP);
			next_st.core_status[`ST_POWERDOWN] = 1'b0;
			// a watchdog wake decides the time-out flag when both arrive together
			next_st.core_status[`ST_TIMEOUT] = !wake_req_i.wdt;
			if (wake_req_i.ext_int) begin
				next_st.irq_control[`IRQ_EXT_FLAG] = 1'b1;
			end
			if (wake_req_i.rb_change) begin
				next_st.irq_control[`IRQ_RB_FLAG] = 1'b1;
			end
			if (wake_req_i.cmp) begin
				next_st.periph_cmp = 1'b1;
			end
			// with global enable the vector follows the next instruction
			if (irq_wake && st.irq_control[`IRQ_GIE]) begin
				next_st.seq = SEQ_WAIT;
			end
		end
	end

	// state register; the block reset gives power-on style contents
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st <= '0;
			st.core_status <= 8'h18;
			st.option <= `OPTION_RST;
			st.portb_direction <= `PORTB_DIR_RST;
			st.seq <= SEQ_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// outputs from the state register; bus ready and response are tied constants
	assign hrdata_o = st.hrdata;
	assign hreadyout_o = 1'b1; // every access completes with no wait state
	assign hresp_o = 1'b0;
	assign pc_load_o = st.pc_load;
	assign pc_value_o = st.pc_value;
	assign option_o = st.option;
	assign portb_direction_o = st.portb_direction;
	assign comparator_o = st.comparator;
	assign irq_o = |(st.evt_status & st.evt_enable);

	// checks on the recorded causes and loaded values
	por_timeout_a: assert property (@(posedge clock_i) disable iff (rst_i)
		reset_req_i.por |=> st.core_status[`ST_TIMEOUT] && pc_load_o && pc_value_o == `PC_RESET)
		else $error("time-out flag or reset pc wrong after power-on");

	por_powerdown_a: assert property (@(posedge clock_i) disable iff (rst_i)
		reset_req_i.por |=> st.core_status[`ST_POWERDOWN] && !st.power_cause[`PCAUSE_POR])
		else $error("power-down flag or cause bit wrong after power-on");

	irq_vector_a: assert property (@(posedge clock_i) disable iff (rst_i)
		(irq_wake && st.irq_control[`IRQ_GIE]) ##1 (core_step_i && !any_reset)
		|=> pc_load_o && pc_value_o == `PC_VECTOR)
		else $error("vector not loaded after the next instruction");

	wake_resume_a: assert property (@(posedge clock_i) disable iff (rst_i)
		wake_go |=> pc_load_o && pc_value_o == 13'($past(pc_i) + `PC_STEP))
		else $error("wake-up did not resume at the next address");

	bor_cause_a: assert property (@(posedge clock_i) disable iff (rst_i)
		(do_wdt || do_master_clear_pin) && !st.ahb_wr |=> $stable(st.power_cause[`PCAUSE_BOR]))
		else $error("brown-out cause bit changed by another reset");

	cmp_wake_a: assert property (@(posedge clock_i) disable iff (rst_i)
		wake_go && wake_req_i.cmp |=> st.periph_cmp)
		else $error("comparator wake did not set its flag");

	master_clear_pin_run_a: assert property (@(posedge clock_i) disable iff (rst_i)
		do_master_clear_pin && !sleeping_i && !st.ahb_wr
		|=> st.core_status == ($past(st.core_status) & ~`ST_TOP_MASK))
		else $error("master clear while running changed kept status bits");

	master_clear_pin_sleep_a: assert property (@(posedge clock_i) disable iff (rst_i)
		do_master_clear_pin && sleeping_i
		|=> st.core_status[7:3] == 5'h02 && pc_value_o == `PC_RESET)
		else $error("master clear in sleep gave wrong status");

	wdt_reset_a: assert property (@(posedge clock_i) disable iff (rst_i)
		do_wdt |=> st.core_status[7:3] == 5'h00 && pc_load_o && pc_value_o == `PC_RESET)
		else $error("watchdog reset left status bits set");

	wake_flags_a: assert property (@(posedge clock_i) disable iff (rst_i)
		wake_go |=> st.core_status[`ST_TIMEOUT] == !$past(wake_req_i.wdt)
			&& !st.core_status[`ST_POWERDOWN])
		else $error("wake-up flags wrong");

	reset_defaults_a: assert property (@(posedge clock_i) disable iff (rst_i)
		any_reset |=> option_o == `OPTION_RST && portb_direction_o == `PORTB_DIR_RST
			&& comparator_o == `CMP_RST)
		else $error("reset defaults not applied");

	cause_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
		addr_take && !hwrite_i && haddr_i[11:2] == `IDX_POWER_CAUSE
		|=> hrdata_o[31:2] == 30'h0000_0000)
		else $error("unimplemented power cause bits read as one");

endmodule

// file: verif/core_model.sv
// stand-in for the core: holds the program counter and retires an instruction every fourth cycle
`timescale 1ns/1ps
module core_model (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic pc_load_i,
	input wire logic [12:0] pc_value_i,
	output logic [12:0] pc_o,
	output logic core_step_o
);
	logic [1:0] phase;
	// a load from the block wins over the step, as a taken branch would
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			phase <= 2'h0;
			pc_o <= 13'h0000;
			core_step_o <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			core_step_o <= (phase == 2'h3);
			if (pc_load_i) begin
				pc_o <= pc_value_i;
			end else if (core_step_o) begin
				pc_o <= pc_o + 13'h0001;
			end
		end
	end
endmodule

// file: verif/test_reset_cause_and_init_state.sv
// self-checking bench for the reset cause block
`timescale 1ns/1ps
`include "reset_cause_consts.svh"
module test_reset_cause_and_init_state;
	import reset_cause_pkg::*;
	logic clock_i, rst_i, sleeping_i, hsel, hwrite, hreadyout, hresp, pc_load, core_step, irq;
	reset_req_t reset_req;
	wake_req_t wake_req;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [12:0] pc_value, pc;
	logic [7:0] option, portb_dir, st;
	logic [5:0] comparator;
	int miscompares, cmp_count;

	// hready of the single slave is its own hreadyout
	reset_cause_and_init_state u_dut (.clock_i(clock_i), .rst_i(rst_i), .reset_req_i(reset_req),
		.wake_req_i(wake_req), .sleeping_i(sleeping_i), .pc_i(pc), .core_step_i(core_step),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
		.hresp_o(hresp), .pc_load_o(pc_load), .pc_value_o(pc_value), .option_o(option),
		.portb_direction_o(portb_dir), .comparator_o(comparator), .irq_o(irq));
	core_model u_core (.clock_i(clock_i), .rst_i(rst_i), .pc_load_i(pc_load),
		.pc_value_i(pc_value), .pc_o(pc), .core_step_o(core_step));

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// bounded wait for hready high at a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge clock_i);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				miscompares++;
				close_out();
			end
			@(posedge clock_i);
		end
	endtask
	// one single word transfer; read data is taken at the end of the data phase
	task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clock_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {20'h00000, idx, 2'h0};
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask
	task automatic rd(input string what, input logic [9:0] idx, input logic [31:0] exp,
		input logic [31:0] mask);
		logic [31:0] q;
		bus(1'b0, idx, 32'h00000000, q);
		chk(what, exp, q & mask);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	// one request cycle; kind 0 expects no load, 1 a reset load, 2 a wake load of pc plus one
	task automatic cause(input reset_req_t r, input wake_req_t w, input logic slp,
		input logic [1:0] kind);
		logic [12:0] pcw;
		@(posedge clock_i);
		reset_req <= r;
		wake_req <= w;
		sleeping_i <= slp;
		#1;
		pcw = pc + 13'h0001;
		@(posedge clock_i);
		reset_req <= 4'h0;
		wake_req <= 4'h0;
		sleeping_i <= 1'b0;
		#1;
		chk("pc_load", kind != 2'h0, pc_load);
		if (kind != 2'h0) begin
			chk("pc_value", (kind == 2'h2) ? pcw : `PC_RESET, pc_value);
		end
	endtask
	task automatic wait_vector();
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			#1;
			n++;
		end while (pc_load !== 1'b1 && n < 12);
		chk("vector", {1'b1, `PC_VECTOR}, {pc_load, pc_value});
	endtask

	task automatic t_reset_values();
		chk("outputs", 32'hFFFF0000, {option, portb_dir, 2'h0, comparator, 7'h00, irq});
		rd("status", `IDX_CORE_STATUS, 32'h18, 32'hFF);
		rd("power_cause", `IDX_POWER_CAUSE, 32'h0, 32'hFFFFFFFF);
	endtask
	task automatic t_reg_access();
		wr(`IDX_COMPARATOR, 32'hFFFFFFFF);
		rd("comparator", `IDX_COMPARATOR, 32'h3F, 32'hFFFFFFFF);
		wr(`IDX_PERIPH_FLAGS, 32'hFFFFFFFF);
		rd("periph", `IDX_PERIPH_FLAGS, 32'h40, 32'hFFFFFFFF);
		wr(`IDX_POWER_CAUSE, 32'hFFFFFFFF);
		rd("power_cause", `IDX_POWER_CAUSE, 32'h3, 32'hFFFFFFFF);
		wr(`IDX_CORE_STATUS, 32'h00);
		rd("status ro flags", `IDX_CORE_STATUS, 32'h18, 32'hFFFFFFFF);
		wr(10'h3FF, 32'hFFFFFFFF);
		rd("unmapped", 10'h3FF, 32'h0, 32'hFFFFFFFF);
	endtask
	task automatic t_power_on();
		wr(`IDX_OPTION, 32'h12);
		wr(`IDX_PORTB_DIR, 32'h00);
		cause(4'b1000, 4'h0, 1'b0, 2'h1);
		chk("por outputs", 32'hFFFF00, {option, portb_dir, 2'h0, comparator});
		rd("power_cause", `IDX_POWER_CAUSE, 32'h1, 32'hFF);
		rd("status", `IDX_CORE_STATUS, 32'h18, 32'hF8);
		wr(`IDX_CORE_STATUS, 32'hA5);
		st = 8'hBD;
		rd("status", `IDX_CORE_STATUS, st, 32'hFF);
	endtask
	// brown-out, master clear running, master clear asleep, watchdog
	task automatic t_resets();
		reset_req_t rq[4];
		rq[0] = 4'b0100;
		rq[1] = 4'b0010;
		rq[2] = 4'b0010;
		rq[3] = 4'b0001;
		for (int i = 0; i < 4; i++) begin
			wr(`IDX_POWER_CAUSE, 32'h3);
			wr(`IDX_OPTION, 32'h5A);
			wr(`IDX_COMPARATOR, 32'h2A);
			wr(`IDX_CORE_STATUS, 32'hE2 + i);
			st = ((8'hE2 + i) & 8'hE7) | (st & 8'h18);
			cause(rq[i], 4'h0, i == 2, 2'h1);
			st = (i == 2) ? ((st & 8'h07) | 8'h10) : (i == 3) ? (st & 8'h07) : (st & 8'h1F);
			rd("status", `IDX_CORE_STATUS, st, 32'hFF);
			rd("power_cause", `IDX_POWER_CAUSE, (i == 0) ? 32'h2 : 32'h3, 32'hFF);
			chk("reset outputs", 32'hFF00, {option, 2'h0, comparator});
		end
	endtask
	task automatic t_priority();
		wr(`IDX_POWER_CAUSE, 32'h3);
		cause(4'b1111, 4'h0, 1'b1, 2'h1);
		rd("power_cause", `IDX_POWER_CAUSE, 32'h1, 32'hFF);
		rd("status", `IDX_CORE_STATUS, 32'h18, 32'hF8);
		wr(`IDX_POWER_CAUSE, 32'h3);
		cause(4'b0111, 4'h0, 1'b1, 2'h1);
		rd("power_cause", `IDX_POWER_CAUSE, 32'h2, 32'hFF);
		rd("status", `IDX_CORE_STATUS, 32'h18, 32'hF8);
		wr(`IDX_CORE_STATUS, 32'hA1);
		st = 8'hB9;
	endtask
	task automatic t_wakes();
		wr(`IDX_OPTION, 32'h5A);
		wr(`IDX_PERIPH_FLAGS, 32'h0);
		cause(4'h0, 4'b0100, 1'b0, 2'h0);
		cause(4'h0, 4'b1000, 1'b1, 2'h2);
		st = st & 8'hE7;
		rd("status", `IDX_CORE_STATUS, st, 32'hFF);
		chk("option", 32'h5A, option);
		wr(`IDX_IRQ_CONTROL, 32'h80);
		cause(4'h0, 4'b0100, 1'b1, 2'h2);
		wait_vector();
		st = (st & 8'hE7) | 8'h10;
		rd("status", `IDX_CORE_STATUS, st, 32'hFF);
		rd("irq_control", `IDX_IRQ_CONTROL, 32'h82, 32'hFF);
		rd("periph", `IDX_PERIPH_FLAGS, 32'h0, 32'hFF);
		wr(`IDX_IRQ_CONTROL, 32'h0);
		cause(4'h0, 4'b0001, 1'b1, 2'h2);
		rd("periph", `IDX_PERIPH_FLAGS, 32'h40, 32'hFF);
		wr(`IDX_PERIPH_FLAGS, 32'h0);
		cause(4'h0, 4'b0010, 1'b1, 2'h2);
		rd("irq_control", `IDX_IRQ_CONTROL, 32'h01, 32'hFF);
		rd("periph", `IDX_PERIPH_FLAGS, 32'h0, 32'hFF);
	endtask
	// every event kind has happened by now; raise, mask and clear the interrupt
	task automatic t_irq();
		rd("evt status", `IDX_EVT_STATUS, 32'h7F, 32'hFFFFFFFF);
		wr(`IDX_EVT_ENABLE, 32'h41);
		#1;
		chk("irq raised", 1'b1, irq);
		wr(`IDX_EVT_ENABLE, 32'h0);
		#1;
		chk("irq masked", 1'b0, irq);
		wr(`IDX_EVT_ENABLE, 32'h1);
		wr(`IDX_EVT_CLEAR, 32'h1);
		#1;
		chk("irq cleared", 1'b0, irq);
		rd("evt status", `IDX_EVT_STATUS, 32'h7E, 32'hFFFFFFFF);
	endtask

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial begin
		rst_i = 1'b1;
		reset_req = 4'h0;
		wake_req = 4'h0;
		sleeping_i = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		miscompares = 0;
		cmp_count = 0;
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		#1;
		t_reset_values();
		t_reg_access();
		t_power_on();
		t_resets();
		t_priority();
		t_wakes();
		t_irq();
		close_out();
	end
endmodule
